// ### hdl/analyzer_modbus_register_map.v
// register bank of the gas analyzer as seen by a modbus protocol engine
//
// Overview of operation
// - current date and time in six read registers
// - time follows device's own running calendar
// - six registers hold last check cycle timestamp
// - valid flags, service, inhibit coils are latched
// - kick coil write one gives single pulse unless the inhibit coil is set
// - eight housekeeping floats as register pairs
// - component status word bits zero to eight
// - failure field bits 0-28, rest zero
// - service request field published as bit field
// - function check and beyond_limits_causes bit fields
// - extended alarm field published as bit field
// - operating state code in one register
// - failure bit 26 tracks thermal regulation fault
// - extended bit 4 flags pressure out of window
`include "analyzer_regmap_consts.vh"

module analyzer_modbus_register_map #(
  parameter integer SEC_CYCLES = `TICK_PERIOD_S * `CLK_HZ
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        req_valid,
  input  wire [1:0]  req_space,
  input  wire        req_write,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  output reg         rsp_valid,
  output wire [15:0] rsp_data,
  output reg         rsp_exception,
  input  wire        time_load,
  input  wire [15:0] load_year,
  input  wire [15:0] load_month,
  input  wire [15:0] load_day,
  input  wire [15:0] load_hour,
  input  wire [15:0] load_minute,
  input  wire [15:0] load_second,
  input  wire        check_done,
  input  wire [28:0] fault_causes,
  input  wire        thermal_regulation_limit_fault,
  input  wire [31:0] service_causes,
  input  wire [31:0] function_check_causes,
  input  wire [31:0] beyond_limits_causes,
  input  wire [3:0]  extra_alarm_causes,
  input  wire        under_range,
  input  wire        over_range,
  input  wire [15:0] op_state_in,
  input  wire [31:0] pressure_meas,
  input  wire [31:0] temperature_meas,
  input  wire [31:0] humidity_meas,
  input  wire [31:0] lamp_current_meas,
  input  wire [31:0] exposure_meas,
  input  wire [31:0] optics_temp_meas,
  input  wire [31:0] detector_temp_meas,
  input  wire [31:0] lamp_health_meas,
  input  wire [15:0] indicator_current_meas,
  input  wire [15:0] led_health_meas,
  output reg         pressure_in_valid,
  output reg         temperature_in_valid,
  output reg         humidity_in_valid,
  output reg         service_mode_switch,
  output reg         control_cycle_inhibit,
  output reg         control_cycle_kick,
  output reg         beyond_limits_flag
);
  // ****************************************
  // running calendar
  // ****************************************
  reg  [31:0] tick_cnt;
  reg  [15:0] year;
  reg  [15:0] month;
  reg  [15:0] day;
  reg  [15:0] hour;
  reg  [15:0] minute;
  reg  [15:0] second;
  reg  [15:0] lc_year;
  reg  [15:0] lc_month;
  reg  [15:0] lc_day;
  reg  [15:0] lc_hour;
  reg  [15:0] lc_minute;
  reg  [15:0] lc_second;
  wire        sec_tick;

  function [15:0] month_days;
    input [15:0] y;
    input [15:0] m;
    begin
      case (m)
        16'h0002: month_days = (y[1:0] == 2'h0) ? 16'h001D : 16'h001C;
        16'h0004, 16'h0006, 16'h0009, 16'h000B: month_days = 16'h001E;
        default: month_days = 16'h001F;
      endcase
    end
  endfunction

  assign sec_tick = (tick_cnt == SEC_CYCLES - 1);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 32'h00000000;
    end else if (sec_tick || time_load) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // leap years by year mod 4, correct across the whole range above 2000 to 2099
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      year   <= `RST_YEAR;
      month  <= `RST_ONE;
      day    <= `RST_ONE;
      hour   <= 16'h0000;
      minute <= 16'h0000;
      second <= 16'h0000;
    end else if (time_load) begin
      year   <= load_year;
      month  <= load_month;
      day    <= load_day;
      hour   <= load_hour;
      minute <= load_minute;
      second <= load_second;
    end else if (sec_tick) begin
      second <= second + 16'h0001;
      if (second >= `MAX_SECOND) begin
        second <= 16'h0000;
        minute <= minute + 16'h0001;
        if (minute >= `MAX_SECOND) begin
          minute <= 16'h0000;
          hour   <= hour + 16'h0001;
          if (hour >= `MAX_HOUR) begin
            hour <= 16'h0000;
            day  <= day + 16'h0001;
            if (day >= month_days(year, month)) begin
              day   <= `RST_ONE;
              month <= month + 16'h0001;
              if (month >= `MAX_MONTH) begin
                month <= `RST_ONE;
                year  <= year + 16'h0001;
              end
            end
          end
        end
      end
    end
  end

  // timestamp of the last completed check cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lc_year   <= `RST_YEAR;
      lc_month  <= `RST_ONE;
      lc_day    <= `RST_ONE;
      lc_hour   <= 16'h0000;
      lc_minute <= 16'h0000;
      lc_second <= 16'h0000;
    end else if (check_done) begin
      lc_year   <= year;
      lc_month  <= month;
      lc_day    <= day;
      lc_hour   <= hour;
      lc_minute <= minute;
      lc_second <= second;
    end
  end

  // ****************************************
  // collective fields and derived values
  // ****************************************
  wire [31:0] fault_word;
  wire [31:0] service_word;
  wire [31:0] extra_word;
  wire [15:0] status_word;
  wire [15:0] op_state;
  wire [15:0] indicator_current;
  wire [15:0] led_health;
  wire        press_alarm;
  wire [4:0]  any_active;

  assign fault_word = {3'b000, fault_causes}
    | ({31'h00000000, thermal_regulation_limit_fault} << `FAIL_TEMP_BIT);
  assign service_word = service_causes & `SERVICE_MASK;
  // a negative pattern is always below the window; nan lands above it
  assign press_alarm = pressure_meas[31] || (pressure_meas < `PRESS_LOW)
    || (pressure_meas > `PRESS_HIGH);
  assign extra_word = {27'h0000000, press_alarm, extra_alarm_causes};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_any
      wire [31:0] field = (g == 0) ? fault_word :
                          (g == 1) ? service_word :
                          (g == 2) ? function_check_causes :
                          (g == 3) ? beyond_limits_causes : extra_word;
      assign any_active[g] = |field;
    end
  endgenerate

  assign op_state = service_mode_switch ? `OPST_MAINT : op_state_in;
  assign status_word = {7'h00, op_state == `OPST_CHECK, service_mode_switch,
    over_range, under_range, any_active};
  assign indicator_current = (indicator_current_meas > `LED_CUR_MAX) ? `LED_CUR_MAX
    : indicator_current_meas;
  assign led_health = (led_health_meas > `LED_HLTH_MAX) ? `LED_HLTH_MAX
    : led_health_meas;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      beyond_limits_flag <= 1'b0;
    end else begin
      beyond_limits_flag <= any_active[3];
    end
  end

  // ****************************************
  // input register read decode
  // ****************************************
  reg  [15:0] rd_val;
  reg  [31:0] w32;
  reg         is32;
  reg         in_ok;

  always @* begin
    rd_val = 16'h0000;
    w32    = 32'h00000000;
    is32   = 1'b0;
    in_ok  = 1'b1;
    case (req_addr)
      `A_YEAR:        rd_val = year;
      `A_MONTH:       rd_val = month;
      `A_DAY:         rd_val = day;
      `A_HOUR:        rd_val = hour;
      `A_MINUTE:      rd_val = minute;
      `A_SECOND:      rd_val = second;
      `A_OP_STATE:    rd_val = op_state;
      `A_LC_YEAR:     rd_val = lc_year;
      `A_LC_MONTH:    rd_val = lc_month;
      `A_LC_DAY:      rd_val = lc_day;
      `A_LC_HOUR:     rd_val = lc_hour;
      `A_LC_MINUTE:   rd_val = lc_minute;
      `A_LC_SECOND:   rd_val = lc_second;
      `A_LED_CUR:     rd_val = indicator_current;
      `A_LED_HLTH:    rd_val = led_health;
      `A_COMP_STATUS: rd_val = status_word;
      `A_FAULT,     `A_FAULT + 16'h0001:     w32 = fault_word;
      `A_SERVICE,   `A_SERVICE + 16'h0001:   w32 = service_word;
      `A_FCHECK,    `A_FCHECK + 16'h0001:    w32 = function_check_causes;
      `A_OOS,       `A_OOS + 16'h0001:       w32 = beyond_limits_causes;
      `A_EXTRA,     `A_EXTRA + 16'h0001:     w32 = extra_word;
      `A_PRESS,     `A_PRESS + 16'h0001:     w32 = pressure_meas;
      `A_TEMP,      `A_TEMP + 16'h0001:      w32 = temperature_meas;
      `A_HUMID,     `A_HUMID + 16'h0001:     w32 = humidity_meas;
      `A_LAMP_CUR,  `A_LAMP_CUR + 16'h0001:  w32 = lamp_current_meas;
      `A_EXPOSURE,  `A_EXPOSURE + 16'h0001:  w32 = exposure_meas;
      `A_OPTICS_T,  `A_OPTICS_T + 16'h0001:  w32 = optics_temp_meas;
      `A_DETECT_T,  `A_DETECT_T + 16'h0001:  w32 = detector_temp_meas;
      `A_LAMP_HLTH, `A_LAMP_HLTH + 16'h0001: w32 = lamp_health_meas;
      default: in_ok = 1'b0;
    endcase
    if (in_ok && (req_addr < `A_COMP_STATUS + 16'h0001) && (req_addr != `A_COMP_STATUS)) begin
      in_ok = 1'b0;
    end
    // all 32-bit pairs start on an even address: even is the high word
    if (w32 != 32'h00000000 || (req_addr >= `A_FAULT && req_addr < `A_OP_STATE)) begin
      is32   = 1'b1;
      rd_val = req_addr[0] ? w32[15:0] : w32[31:16];
    end
  end

  // ****************************************
  // holding and coil decode
  // ****************************************
  wire        hold_lo_ok;
  wire        hold_pw_ok;
  wire        hold_ok;
  wire [3:0]  hold_idx;
  wire        coil_ok;
  wire        coil_val;
  wire        acc;
  wire        hold_wr;
  wire [15:0] mem_q;
  wire [15:0] hold_off;
  wire [15:0] pass_off;

  assign hold_off   = req_addr - `H_BASE;
  assign pass_off   = req_addr - `H_PASS;
  assign hold_lo_ok = (req_addr >= `H_BASE) && (req_addr <= `H_LAST)
    && (req_addr != `H_GAP_LO) && (req_addr != `H_GAP_HI);
  assign hold_pw_ok = (req_addr >= `H_PASS) && (req_addr <= `H_PASS_LAST);
  assign hold_ok    = hold_lo_ok || hold_pw_ok;
  assign hold_idx   = hold_pw_ok ? (`H_PASS_IDX + pass_off[3:0]) : hold_off[3:0];
  assign coil_ok    = (req_addr >= `C_P_VALID) && (req_addr <= `C_INHIBIT);
  assign acc        = req_valid && (req_space == `SP_HOLDING) && hold_ok;
  assign hold_wr    = acc && req_write;

  holding_store u_store (
    .clk     (clk),
    .wr_en   (hold_wr),
    .wr_idx  (hold_idx),
    .wr_data (req_wdata),
    .rd_idx  (hold_idx),
    .rd_data (mem_q)
  );

  // the kick coil reads back zero: it stores nothing
  assign coil_val = (req_addr == `C_P_VALID) ? pressure_in_valid :
                    (req_addr == `C_T_VALID) ? temperature_in_valid :
                    (req_addr == `C_H_VALID) ? humidity_in_valid :
                    (req_addr == `C_SERVICE) ? service_mode_switch :
                    (req_addr == `C_INHIBIT) ? control_cycle_inhibit : 1'b0;

  // ****************************************
  // coil state and kick pulse
  // ****************************************
  wire coil_wr;
  wire coil_on;

  assign coil_wr = req_valid && req_write && (req_space == `SP_COIL) && coil_ok;
  assign coil_on = (req_wdata == `COIL_ON);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pressure_in_valid     <= 1'b0;
      temperature_in_valid  <= 1'b0;
      humidity_in_valid     <= 1'b0;
      service_mode_switch   <= 1'b0;
      control_cycle_inhibit <= 1'b0;
      control_cycle_kick    <= 1'b0;
    end else begin
      // a kick while inhibited is dropped, never held for later
      control_cycle_kick <= coil_wr && (req_addr == `C_KICK) && coil_on
        && !control_cycle_inhibit;
      if (coil_wr) begin
        case (req_addr)
          `C_P_VALID: pressure_in_valid     <= coil_on;
          `C_T_VALID: temperature_in_valid  <= coil_on;
          `C_H_VALID: humidity_in_valid     <= coil_on;
          `C_SERVICE: service_mode_switch   <= coil_on;
          `C_INHIBIT: control_cycle_inhibit <= coil_on;
          default:    control_cycle_inhibit <= control_cycle_inhibit;
        endcase
      end
    end
  end

  // ****************************************
  // answer path with low word snapshot
  // ****************************************
  reg  [15:0] rsp_q;
  reg         from_mem;
  reg  [15:0] shadow;
  reg  [15:0] shadow_addr;
  reg         shadow_ok;
  reg  [15:0] next_rsp;
  reg         next_exc;
  reg         next_mem;

  always @* begin
    next_rsp = 16'h0000;
    next_exc = 1'b0;
    next_mem = 1'b0;
    case (req_space)
      `SP_INPUT: begin
        if (!in_ok) begin
          next_exc = 1'b1;
          next_rsp = `EXC_ADDRESS;
        end else if (req_write) begin
          next_exc = 1'b1;
          next_rsp = `EXC_FUNCTION;
        end else if (is32 && req_addr[0] && shadow_ok && shadow_addr == req_addr) begin
          next_rsp = shadow;
        end else begin
          next_rsp = rd_val;
        end
      end
      `SP_HOLDING: begin
        next_exc = !hold_ok;
        next_rsp = hold_ok ? req_wdata : `EXC_ADDRESS;
        next_mem = hold_ok && !req_write;
      end
      `SP_COIL: begin
        next_exc = !coil_ok;
        next_rsp = !coil_ok ? `EXC_ADDRESS : req_write ? req_wdata
          : {15'h0000, coil_val};
      end
      default: begin
        next_exc = 1'b1;
        next_rsp = `EXC_FUNCTION;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid     <= 1'b0;
      rsp_exception <= 1'b0;
      rsp_q         <= 16'h0000;
      from_mem      <= 1'b0;
      shadow        <= 16'h0000;
      shadow_addr   <= 16'h0000;
      shadow_ok     <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_exception <= next_exc;
        rsp_q         <= next_rsp;
        from_mem      <= next_mem;
        // the high word read freezes its partner so the pair cannot tear
        shadow_ok     <= (req_space == `SP_INPUT) && !req_write && is32
          && !req_addr[0];
        shadow        <= w32[15:0];
        shadow_addr   <= req_addr + 16'h0001;
      end
    end
  end

  assign rsp_data = from_mem ? mem_q : rsp_q;
endmodule // analyzer_modbus_register_map

// ### hdl/analyzer_regmap_consts.vh
// constants for the analyzer register bank: addresses, fields, limits, timing
`ifndef ANALYZER_REGMAP_CONSTS_VH
`define ANALYZER_REGMAP_CONSTS_VH
// ****************************************
// request spaces and exception codes
// ****************************************
`define SP_INPUT      2'h0
`define SP_HOLDING    2'h1
`define SP_COIL       2'h2
`define EXC_FUNCTION  16'h0001
`define EXC_ADDRESS   16'h0002
// ****************************************
// input register addresses
// ****************************************
`define A_YEAR        16'h1498
`define A_MONTH       16'h1499
`define A_DAY         16'h149A
`define A_HOUR        16'h149B
`define A_MINUTE      16'h149C
`define A_SECOND      16'h149D
`define A_FAULT       16'h149E
`define A_SERVICE     16'h14A0
`define A_FCHECK      16'h14A2
`define A_OOS         16'h14A4
`define A_EXTRA       16'h14A6
`define A_PRESS       16'h14A8
`define A_TEMP        16'h14AA
`define A_HUMID       16'h14AC
`define A_LAMP_CUR    16'h14AE
`define A_EXPOSURE    16'h14B0
`define A_OPTICS_T    16'h14B2
`define A_DETECT_T    16'h14B4
`define A_LAMP_HLTH   16'h14B6
`define A_OP_STATE    16'h14B8
`define A_LC_YEAR     16'h14B9
`define A_LC_MONTH    16'h14BA
`define A_LC_DAY      16'h14BB
`define A_LC_HOUR     16'h14BC
`define A_LC_MINUTE   16'h14BD
`define A_LC_SECOND   16'h14BE
`define A_LED_CUR     16'h14BF
`define A_LED_HLTH    16'h14C0
`define A_COMP_STATUS 16'h138A
// ****************************************
// holding registers and coils
// ****************************************
`define H_BASE        16'h1770
`define H_GAP_LO      16'h1774
`define H_GAP_HI      16'h1775
`define H_LAST        16'h1777
`define H_PASS        16'h1AF4
`define H_PASS_LAST   16'h1AF6
`define H_PASS_IDX    4'h8
`define C_P_VALID     16'h1770
`define C_T_VALID     16'h1771
`define C_H_VALID     16'h1772
`define C_SERVICE     16'h1773
`define C_KICK        16'h1774
`define C_INHIBIT     16'h1775
`define COIL_ON       16'hFF00
// ****************************************
// fields, limits, reset values
// ****************************************
`define FAIL_TEMP_BIT 5'h1A
`define SERVICE_MASK  32'h01FFFFFF
`define PRESS_LOW     32'h44480000
`define PRESS_HIGH    32'h44A28000
`define LED_CUR_MAX   16'h00C8
`define LED_HLTH_MAX  16'h0064
`define OPST_MAINT    16'h0003
`define OPST_CHECK    16'h0005
`define MAX_SECOND    16'h003B
`define MAX_HOUR      16'h0017
`define MAX_MONTH     16'h000C
`define RST_YEAR      16'h07D1
`define RST_ONE       16'h0001
`define CLK_HZ        25000000
`define TICK_PERIOD_S 1
`endif

// ### hdl/holding_store.v
// holding register storage, 16 words of 16 bits with registered read data
module holding_store (
  input  wire        clk,
  input  wire        wr_en,
  input  wire [3:0]  wr_idx,
  input  wire [15:0] wr_data,
  input  wire [3:0]  rd_idx,
  output reg  [15:0] rd_data
);
  reg [15:0] mem [0:15];

  // no reset: contents are undefined until the master writes them
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule // holding_store

// ### testbench/analyzer_modbus_register_map_properties.sv
// port assertions for the analyzer register bank
`include "analyzer_regmap_consts.vh"
module analyzer_regmap_checker (
  input wire        clk,
  input wire        arst_n,
  input wire        req_valid,
  input wire [1:0]  req_space,
  input wire        req_write,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire        rsp_valid,
  input wire [15:0] rsp_data,
  input wire        rsp_exception,
  input wire        pressure_in_valid,
  input wire        control_cycle_inhibit,
  input wire        control_cycle_kick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire cw = req_valid && req_write && req_space == `SP_COIL;
  // ****
  // refusals, coils, trigger
  // ****
  sequence s_kick_go;
    cw && req_addr == `C_KICK && req_wdata == `COIL_ON && !control_cycle_inhibit;
  endsequence
  sequence s_pulse;
    control_cycle_kick ##1 !control_cycle_kick;
  endsequence
  property p_in_write;
    req_valid && req_write && req_space == `SP_INPUT |=>
      rsp_valid && rsp_exception && rsp_data == `EXC_FUNCTION;
  endproperty
  property p_bad_space;
    req_valid && req_space == 2'h3 |=> rsp_valid && rsp_exception && rsp_data == `EXC_FUNCTION;
  endproperty
  property p_kick;
    s_kick_go |=> s_pulse;
  endproperty
  property p_kick_held;
    cw && req_addr == `C_KICK && control_cycle_inhibit |=> !control_cycle_kick;
  endproperty
  property p_kick_cause;
    $rose(control_cycle_kick) |-> $past(cw) && $past(req_addr) == `C_KICK;
  endproperty
  property p_pvalid_set;
    cw && req_addr == `C_P_VALID |=> pressure_in_valid == ($past(req_wdata) == `COIL_ON);
  endproperty
  property p_pvalid_hold;
    !(cw && req_addr == `C_P_VALID) |=> $stable(pressure_in_valid);
  endproperty
  property p_inhibit_hold;
    !(cw && req_addr == `C_INHIBIT) |=> $stable(control_cycle_inhibit);
  endproperty
  a_in_write: assert property (p_in_write) else $error("input write not refused");
  a_bad_space: assert property (p_bad_space) else $error("bad space not refused");
  a_kick: assert property (p_kick) else $error("trigger pulse wrong");
  a_kick_held: assert property (p_kick_held) else $error("trigger while inhibited");
  a_kick_cause: assert property (p_kick_cause) else $error("trigger without write");
  a_pvalid_set: assert property (p_pvalid_set) else $error("flag not written");
  a_pvalid_hold: assert property (p_pvalid_hold) else $error("flag moved");
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit moved");
endmodule  // analyzer_regmap_checker

bind analyzer_modbus_register_map analyzer_regmap_checker u_chk (
  .clk, .arst_n, .req_valid, .req_space, .req_write, .req_addr, .req_wdata, .rsp_valid,
  .rsp_data, .rsp_exception, .pressure_in_valid, .control_cycle_inhibit, .control_cycle_kick);

// ### testbench/modbus_master_model.sv
// master model: one request at a time on the register port
module modbus_master_model (
  input  wire         clk,
  output logic        req_valid,
  output logic [1:0]  req_space,
  output logic        req_write,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input  wire         rsp_valid,
  input  wire  [15:0] rsp_data,
  input  wire         rsp_exception
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req_space = 2'h0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // ****
  // request, then a bounded wait for the answer
  // ****
  task automatic xfer(input logic [1:0] sp, input logic w, input logic [15:0] a, d,
                      output logic [15:0] q, output logic e, output logic ok);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_space = sp;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // released lines flip so a design that latches late reads garbage
    req_addr = ~a;
    req_wdata = ~d;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rsp_valid === 1'b1) begin
        q = rsp_data;
        e = rsp_exception;
        ok = 1'b1;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule  // modbus_master_model

// ### testbench/analyzer_modbus_register_map_tb.sv
// self-checking bench for the analyzer register bank
`include "analyzer_regmap_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module analyzer_modbus_register_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // short second so calendar rollover fits in about a hundred cycles
  localparam integer SEC = 100;
  logic        clk, arst_n, time_load, check_done, under_range, over_range, tfault;
  logic        req_valid, req_write, rsp_valid, rsp_exception;
  logic [1:0]  req_space;
  logic [15:0] req_addr, req_wdata, rsp_data, op_state_in, indicator_current_meas, led_health_meas;
  logic [28:0] fault_causes;
  logic [31:0] service_causes, function_check_causes, beyond_limits_causes;
  logic [3:0]  extra_alarm_causes;
  logic [31:0] meas [8];
  logic [15:0] ld [6];
  wire  [4:0]  coil;
  wire         kick, bflag;
  int          mismatches = 0, samples_checked = 0;
  analyzer_modbus_register_map #(.SEC_CYCLES(SEC)) u_analyzer_modbus_register_map (
    .clk, .arst_n, .req_valid, .req_space, .req_write, .req_addr, .req_wdata, .rsp_valid,
    .rsp_data, .rsp_exception, .time_load, .load_year(ld[0]), .load_month(ld[1]),
    .load_day(ld[2]), .load_hour(ld[3]), .load_minute(ld[4]), .load_second(ld[5]),
    .check_done, .fault_causes, .thermal_regulation_limit_fault(tfault), .service_causes,
    .function_check_causes, .beyond_limits_causes, .extra_alarm_causes, .under_range,
    .over_range, .op_state_in, .pressure_meas(meas[0]), .temperature_meas(meas[1]),
    .humidity_meas(meas[2]), .lamp_current_meas(meas[3]), .exposure_meas(meas[4]),
    .optics_temp_meas(meas[5]), .detector_temp_meas(meas[6]), .lamp_health_meas(meas[7]),
    .indicator_current_meas, .led_health_meas, .pressure_in_valid(coil[0]),
    .temperature_in_valid(coil[1]), .humidity_in_valid(coil[2]), .service_mode_switch(coil[3]),
    .control_cycle_inhibit(coil[4]), .control_cycle_kick(kick), .beyond_limits_flag(bflag));
  modbus_master_model master (.clk, .req_valid, .req_space, .req_write, .req_addr,
    .req_wdata, .rsp_valid, .rsp_data, .rsp_exception);
  // ****
  // shared tasks
  // ****
  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xchk(input logic [1:0] sp, input logic w, input logic [15:0] a, d,
                      input logic [16:0] exp);
    logic [15:0] q;
    logic        e, ok;
    master.xfer(sp, w, a, d, q, e, ok);
    if (!ok) begin
      mismatches++;
      summarize();
    end
    `CHK({e, q}, exp)
  endtask
  task automatic rd16(input logic [15:0] a, input logic [15:0] v);
    xchk(`SP_INPUT, 1'b0, a, 16'h0000, {1'b0, v});
  endtask
  task automatic rd32(input logic [15:0] a, input logic [31:0] v);
    rd16(a, v[31:16]);
    rd16(a + 16'h0001, v[15:0]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_clock();
    logic [15:0] v [6];
    int          i;
    rd16(`A_YEAR, 16'h07D1);
    rd16(`A_LC_DAY, 16'h0001);
    ld = '{16'h07E7, 16'h000C, 16'h001F, 16'h0017, 16'h003B, 16'h003B};
    tick(1);
    time_load = 1'b1;
    tick(1);
    time_load = 1'b0;
    tick(SEC + 4);
    v = '{16'h07E8, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    for (i = 0; i < 6; i++) rd16(`A_YEAR + 16'(i), v[i]);
    check_done = 1'b1;
    tick(1);
    check_done = 1'b0;
    for (i = 0; i < 6; i++) rd16(`A_LC_YEAR + 16'(i), v[i]);
    $display("clock test done");
  endtask
  task automatic t_fields();
    fault_causes = 29'h100000F1;
    tfault = 1'b1;
    service_causes = 32'hFFFFFFFF;
    function_check_causes = 32'hA5A50F0F;
    beyond_limits_causes = 32'h80000001;
    extra_alarm_causes = 4'h5;
    meas[0] = 32'h44480000;
    under_range = 1'b1;
    tick(2);
    rd32(`A_FAULT, 32'h140000F1);
    rd32(`A_SERVICE, 32'h01FFFFFF);
    rd32(`A_FCHECK, 32'hA5A50F0F);
    rd32(`A_OOS, 32'h80000001);
    `CHK(bflag, 1'b1)
    rd32(`A_EXTRA, 32'h00000005);
    rd16(`A_COMP_STATUS, 16'h003F);
    meas[0] = 32'h44A28001;
    tick(2);
    rd32(`A_EXTRA, 32'h00000015);
    // low word changes between the two halves; the pair must stay whole
    rd16(`A_FAULT, 16'h1400);
    fault_causes = 29'h100000F2;
    tfault = 1'b0;
    rd16(`A_FAULT + 16'h0001, 16'h00F1);
    rd32(`A_FAULT, 32'h100000F2);
    $display("fields test done");
  endtask
  task automatic t_values();
    int i;
    for (i = 0; i < 8; i++) meas[i] = {8'h40, 8'(i), 8'hA5, 8'(i)};
    op_state_in = 16'h0005;
    over_range = 1'b1;
    tick(2);
    for (i = 0; i < 8; i++) rd32(`A_PRESS + 16'(2 * i), {8'h40, 8'(i), 8'hA5, 8'(i)});
    rd16(`A_OP_STATE, 16'h0005);
    rd16(`A_COMP_STATUS, 16'h017F);
    rd16(`A_LED_CUR, 16'h00C8);
    rd16(`A_LED_HLTH, 16'h0064);
    $display("values test done");
  endtask
  task automatic t_coils();
    int i;
    xchk(`SP_COIL, 1'b1, `C_KICK, `COIL_ON, {1'b0, `COIL_ON});
    `CHK(kick, 1'b1)
    tick(1);
    `CHK(kick, 1'b0)
    for (i = 0; i < 5; i++) xchk(`SP_COIL, 1'b1, 16'h1770 + 16'(i + i / 4), `COIL_ON, 17'h0FF00);
    rd16(`A_OP_STATE, 16'h0003);
    `CHK(coil, 5'h1F)
    xchk(`SP_COIL, 1'b1, `C_KICK, `COIL_ON, {1'b0, `COIL_ON});
    `CHK(kick, 1'b0)
    `CHK(coil, 5'h1F)
    // any value other than the on code switches a coil off
    for (i = 0; i < 5; i++) xchk(`SP_COIL, 1'b1, 16'h1770 + 16'(i + i / 4), 16'h0001, 17'h00001);
    `CHK(coil, 5'h00)
    $display("coil test done");
  endtask
  task automatic t_hold();
    xchk(`SP_HOLDING, 1'b1, `H_BASE, 16'h1234, 17'h01234);
    xchk(`SP_HOLDING, 1'b1, `H_LAST, 16'hABCD, 17'h0ABCD);
    xchk(`SP_HOLDING, 1'b0, `H_BASE, 16'h0000, 17'h01234);
    xchk(`SP_HOLDING, 1'b0, `H_LAST, 16'h0000, 17'h0ABCD);
    xchk(`SP_INPUT, 1'b1, `A_YEAR, 16'h0001, {1'b1, `EXC_FUNCTION});
    xchk(2'h3, 1'b0, `A_YEAR, 16'h0000, {1'b1, `EXC_FUNCTION});
    xchk(`SP_HOLDING, 1'b0, `H_GAP_LO, 16'h0000, {1'b1, `EXC_ADDRESS});
    xchk(`SP_INPUT, 1'b0, `A_LED_HLTH + 16'h0001, 16'h0000, {1'b1, `EXC_ADDRESS});
    $display("holding test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    {time_load, check_done, under_range, over_range, tfault} = 5'h00;
    {fault_causes, extra_alarm_causes} = 33'h000000000;
    {service_causes, function_check_causes, beyond_limits_causes} = 96'h0;
    op_state_in = 16'h0002;
    indicator_current_meas = 16'h00C9;
    led_health_meas = 16'h0065;
    meas = '{default: 32'h3F800000};
    ld = '{default: 16'h0000};
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_clock();
    t_fields();
    t_values();
    t_coils();
    t_hold();
    summarize();
  end
endmodule  // analyzer_modbus_register_map_tb
